// [common/elt_defines.svh]
// constants of the event logic, timer and counter block: offsets, resets, timing
// assumes a 40 MHz clock and a classic Wishbone slave with 32-bit data
//
// Overview of operation
// [RULE1] armed inhibit keeps alarm off in zone until value leaves and re-enters
// [RULE2] inhibit selector off/1/2/3, resets off; 1 arms at power-on and standby end
// [RULE3] setting 2 also arms inhibit whenever the set value changes
// [RULE4] setting 3 applies no suppression, plain control-mode event
// [RULE5] settings 1 or 2 force the alarm on during scale-over
// [RULE6] setting 3 forces the alarm off during scale-over
// [RULE7] standby enable, resets off; off disables output during inhibit or standby
// [RULE8] combiner gives AND, OR or XOR of gated inputs; AND by default
// [RULE9] combiner drives one of event relays 1-3 or digital outputs 1-3
// [RULE10] each combiner source is none or one of ten inputs, resets none
// [RULE11] a source of none reads logic 0 whatever its gating
// [RULE12] gating passes the input level or its complement; pass-through default
// [RULE13] toggle gating flips on each input rising edge and holds otherwise
// [RULE14] an input feeding combiner or timer still serves its other function
// [RULE15] only digital outputs 4 and 5 take the timer or counter
// [RULE16] timer/counter selector chooses timer or counter, resets timer
// [RULE17] timer turns output on after input stays on for the preset time
// [RULE18] timer preset off or 1 to 5000 seconds, resets off
// [RULE19] timer preset of 1 second holds the output on continuously; code turns it on after 1 s of input and off when input drops
// [RULE20] counter reaching preset emits a one-second pulse regardless of control
// [RULE21] counter preset off or 1 to 5000 counts, resets off
// [RULE22] external source holds each counted pulse at least 100 ms
// [RULE23] timer source of none takes no action whatever inputs do
// [RULE24] input state recognised only after 0.1 s stable; source holds that long
// [RULE25] timer clears when input drops early; counter restarts after each pulse
// [RULE26] preset off keeps the timer/counter output inactive
`ifndef ELT_DEFINES_SVH
`define ELT_DEFINES_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ELT_CLOCK_HZ 40000000
`define ELT_DEBOUNCE_MS 100
`define ELT_DEBOUNCE_CYCLES ((`ELT_CLOCK_HZ / 1000) * `ELT_DEBOUNCE_MS)
`define ELT_SECOND_S 1
`define ELT_SECOND_CYCLES (`ELT_CLOCK_HZ * `ELT_SECOND_S)
`define ELT_PRESET_MAX 13'h1388

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ELT_REG_EVENT 4'h0
`define ELT_REG_COMBINER 4'h4
`define ELT_REG_TIMER 4'h8
`define ELT_REG_STATUS 4'hC

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ELT_RST_EVENT 32'h0000_0000
`define ELT_RST_COMBINER 32'h0000_0000
`define ELT_RST_TIMER 32'h0000_0000

`endif

// [common/elt_pkg.sv]
// types of the event logic, timer and counter block
// assumes the register layout documented in the hand-over
package elt_pkg;
    typedef enum logic [1:0] {ELT_IH_OFF = 2'h0, ELT_IH_ONE = 2'h1, ELT_IH_TWO = 2'h2, ELT_IH_THREE = 2'h3}
        elt_inhibit_t;
    typedef enum logic [1:0] {ELT_GATE_BUF = 2'h0, ELT_GATE_INV = 2'h1, ELT_GATE_TOGGLE = 2'h2} elt_gate_t;
    typedef enum logic [1:0] {ELT_FN_AND = 2'h0, ELT_FN_OR = 2'h1, ELT_FN_XOR = 2'h2} elt_func_t;
    typedef enum logic [1:0] {ELT_TC_IDLE = 2'b01, ELT_TC_PULSE = 2'b10} elt_tc_state_t;
    // event register: bits 1:0 inhibit, bit 2 standby enable
    typedef struct packed {
        logic [28:0] unused;
        logic standbyEventEnable;
        elt_inhibit_t inhibitSelect;
    } elt_event_cfg_t;
    // combiner register
    typedef struct packed {
        logic [9:0] unused;
        elt_gate_t secondInputGating;
        logic [3:0] secondLogicSource;
        logic [1:0] unused2;
        elt_gate_t firstInputGating;
        logic [3:0] firstLogicSource;
        logic unused1;
        logic [2:0] target;
        logic [1:0] unused0;
        elt_func_t logicFunctionSelect;
    } elt_comb_cfg_t;
    // timer register
    typedef struct packed {
        logic [2:0] unused;
        logic [12:0] preset;
        logic [7:0] unused1;
        logic [3:0] timerSource;
        logic actionModeSelect;
        logic unused0;
        logic [1:0] target;
    } elt_tc_cfg_t;
endpackage : elt_pkg

// [src/elt_top.sv]
// event output logic: alarm inhibit, two-input combiner, timer/counter, Wishbone registers
// assumes digital inputs arrive unsynchronised from pins; alarm inputs come from logic on this clock
`include "elt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module elt_top
    import elt_pkg::*;
#(
    parameter logic [21:0] DEBOUNCE_CYCLES = 22'(`ELT_DEBOUNCE_CYCLES),
    parameter logic [25:0] SECOND_CYCLES = 26'(`ELT_SECOND_CYCLES)
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [3:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    // alarm sources
    input wire logic processInZone,
    input wire logic scaleOver,
    input wire logic standbyState,
    input wire logic setValueChanged,
    // pins
    input wire logic [9:0] digitalInput,
    output logic [2:0] eventRelay,
    output logic [4:0] digitalOutput
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic pickInput(input logic [3:0] src, input logic [9:0] level);
        pickInput = 1'b0;
        if (src != 4'h0 && src <= 4'hA) begin
            pickInput = level[src - 4'h1];
        end
    endfunction : pickInput

    function automatic logic [31:0] byteWrite(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] sel);
        byteWrite = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                byteWrite[8*i +: 8] = data[8*i +: 8];
            end
        end
    endfunction : byteWrite

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    elt_event_cfg_t eventCfg_q;
    elt_comb_cfg_t combCfg_q;
    elt_tc_cfg_t tcCfg_q;
    logic ack_q;
    logic [31:0] datOut_q;
    logic [31:0] status;
    logic wbWrite;

    // the write lands on the edge at which the master sees ack, not on the edge that takes the request
    assign wbWrite = wbCyc && wbStb && wbWe && ack_q;

    // one wait state: ack follows the request by one edge, unmapped reads return zero
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
            datOut_q <= 32'h0000_0000;
        end else begin
            ack_q <= wbCyc && wbStb && !ack_q;
            unique case (wbAdr)
                `ELT_REG_EVENT: datOut_q <= {29'h0, eventCfg_q[2:0]};
                `ELT_REG_COMBINER: datOut_q <= {10'h0, combCfg_q[21:16], 2'h0, combCfg_q[13:8], 1'b0,
                    combCfg_q[6:4], 2'h0, combCfg_q[1:0]};
                `ELT_REG_TIMER: datOut_q <= {3'h0, tcCfg_q[28:16], 8'h0, tcCfg_q[7:4], tcCfg_q[3], 1'b0,
                    tcCfg_q[1:0]};
                `ELT_REG_STATUS: datOut_q <= status;
                default: datOut_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            eventCfg_q <= `ELT_RST_EVENT; // RULE2 RULE7
            combCfg_q <= `ELT_RST_COMBINER; // RULE8 RULE10 RULE12
            tcCfg_q <= `ELT_RST_TIMER; // RULE16 RULE18 RULE21
        end else if (wbWrite) begin
            unique case (wbAdr)
                `ELT_REG_EVENT: eventCfg_q <= byteWrite(eventCfg_q, wbDatIn, wbSel);
                `ELT_REG_COMBINER: combCfg_q <= byteWrite(combCfg_q, wbDatIn, wbSel);
                `ELT_REG_TIMER: tcCfg_q <= byteWrite(tcCfg_q, wbDatIn, wbSel);
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // input synchronisers and debounce
    // ---------------------------------------------------------------
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic [9:0] level_q;
    logic [9:0] levelPrev_q;
    logic [21:0] dbCount_q [10];

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
        end else begin
            sync1_q <= digitalInput;
            sync2_q <= sync1_q;
        end
    end

    // a new level is accepted only after it held for the full window, so short glitches vanish
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            level_q <= 10'h000;
            levelPrev_q <= 10'h000;
            for (int i = 0; i < 10; i++) begin
                dbCount_q[i] <= 22'h0;
            end
        end else begin
            levelPrev_q <= level_q;
            for (int i = 0; i < 10; i++) begin
                if (sync2_q[i] == level_q[i]) begin
                    dbCount_q[i] <= 22'h0;
                end else if (dbCount_q[i] == DEBOUNCE_CYCLES - 22'h1) begin
                    level_q[i] <= sync2_q[i]; // RULE24 RULE22
                    dbCount_q[i] <= 22'h0;
                end else begin
                    dbCount_q[i] <= dbCount_q[i] + 22'h1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // alarm inhibit
    // ---------------------------------------------------------------
    logic inhibitArmed_q;
    logic standbyPrev_q;
    logic alarmOut;
    logic inhibitUsed;
    logic armNow;

    // arming events also suppress in their own cycle, so no one-cycle relay glitch follows standby
    assign armNow = (standbyPrev_q && !standbyState)
        || (eventCfg_q.inhibitSelect == ELT_IH_TWO && setValueChanged); // RULE2 RULE3
    assign inhibitUsed = eventCfg_q.inhibitSelect == ELT_IH_ONE || eventCfg_q.inhibitSelect == ELT_IH_TWO;

    // armed out of reset stands for power-on arming
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            inhibitArmed_q <= 1'b1; // RULE2
            standbyPrev_q <= 1'b0;
        end else begin
            standbyPrev_q <= standbyState;
            if (standbyPrev_q && !standbyState) begin
                inhibitArmed_q <= 1'b1; // RULE2
            end else if (eventCfg_q.inhibitSelect == ELT_IH_TWO && setValueChanged) begin
                inhibitArmed_q <= 1'b1; // RULE3
            end else if (!processInZone) begin
                inhibitArmed_q <= 1'b0; // RULE1
            end
        end
    end

    always_comb begin
        alarmOut = processInZone; // RULE4
        if (standbyState && !eventCfg_q.standbyEventEnable) begin
            alarmOut = 1'b0; // RULE7
        end else if (scaleOver && inhibitUsed) begin
            alarmOut = 1'b1; // RULE5
        end else if (scaleOver && eventCfg_q.inhibitSelect == ELT_IH_THREE) begin
            alarmOut = 1'b0; // RULE6
        end else if (inhibitUsed && (inhibitArmed_q || armNow)) begin
            alarmOut = 1'b0; // RULE1 RULE7
        end
    end

    // ---------------------------------------------------------------
    // logic combiner
    // ---------------------------------------------------------------
    logic [1:0] toggle_q;
    logic [1:0] rawIn;
    logic [1:0] riseIn;
    logic [1:0] gated;
    logic combOut;

    // levels are only read here and the other functions read them too
    assign rawIn[0] = pickInput(combCfg_q.firstLogicSource, level_q); // RULE14
    assign rawIn[1] = pickInput(combCfg_q.secondLogicSource, level_q);
    assign riseIn[0] = rawIn[0] && !pickInput(combCfg_q.firstLogicSource, levelPrev_q);
    assign riseIn[1] = rawIn[1] && !pickInput(combCfg_q.secondLogicSource, levelPrev_q);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            toggle_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (riseIn[i]) begin
                    toggle_q[i] <= !toggle_q[i]; // RULE13
                end
            end
        end
    end

    always_comb begin
        elt_gate_t g;
        logic [3:0] s;
        g = ELT_GATE_BUF;
        s = 4'h0;
        for (int i = 0; i < 2; i++) begin
            g = (i == 0) ? combCfg_q.firstInputGating : combCfg_q.secondInputGating;
            s = (i == 0) ? combCfg_q.firstLogicSource : combCfg_q.secondLogicSource;
            if (s == 4'h0 || s > 4'hA) begin
                gated[i] = 1'b0; // RULE11 RULE10
            end else if (g == ELT_GATE_INV) begin
                gated[i] = !rawIn[i]; // RULE12
            end else if (g == ELT_GATE_TOGGLE) begin
                gated[i] = toggle_q[i]; // RULE13
            end else begin
                gated[i] = rawIn[i]; // RULE12
            end
        end
    end

    always_comb begin
        unique case (combCfg_q.logicFunctionSelect)
            ELT_FN_OR: combOut = gated[0] | gated[1]; // RULE8
            ELT_FN_XOR: combOut = gated[0] ^ gated[1]; // RULE8
            default: combOut = gated[0] & gated[1]; // RULE8
        endcase
    end

    // ---------------------------------------------------------------
    // timer / counter
    // ---------------------------------------------------------------
    elt_tc_state_t tcState_q;
    logic [25:0] secPre_q;
    logic [12:0] tcCount_q;
    logic tcIn;
    logic tcRise;
    logic tcOut;
    logic presetOn;

    assign tcIn = pickInput(tcCfg_q.timerSource, level_q); // RULE23 RULE14
    assign tcRise = tcIn && !pickInput(tcCfg_q.timerSource, levelPrev_q);
    assign presetOn = tcCfg_q.preset != 13'h0 && tcCfg_q.preset <= `ELT_PRESET_MAX; // RULE18 RULE21

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tcState_q <= ELT_TC_IDLE;
            secPre_q <= 26'h0;
            tcCount_q <= 13'h0;
        end else if (!tcCfg_q.actionModeSelect) begin
            tcState_q <= ELT_TC_IDLE;
            if (!tcIn || !presetOn) begin
                secPre_q <= 26'h0; // RULE25
                tcCount_q <= 13'h0; // RULE25
            end else if (secPre_q == SECOND_CYCLES - 26'h1) begin
                secPre_q <= 26'h0;
                if (tcCount_q < tcCfg_q.preset) begin
                    tcCount_q <= tcCount_q + 13'h1; // RULE17
                end
            end else begin
                secPre_q <= secPre_q + 26'h1;
            end
        end else begin
            unique case (tcState_q)
                ELT_TC_IDLE: begin
                    secPre_q <= 26'h0;
                    if (!presetOn) begin
                        tcCount_q <= 13'h0; // RULE26
                    end else if (tcRise && tcCount_q + 13'h1 >= tcCfg_q.preset) begin
                        tcCount_q <= 13'h0; // RULE25
                        tcState_q <= ELT_TC_PULSE; // RULE20
                    end else if (tcRise) begin
                        tcCount_q <= tcCount_q + 13'h1;
                    end
                end
                ELT_TC_PULSE: begin
                    if (secPre_q == SECOND_CYCLES - 26'h1) begin
                        secPre_q <= 26'h0;
                        tcState_q <= ELT_TC_IDLE; // RULE20
                    end else begin
                        secPre_q <= secPre_q + 26'h1;
                    end
                end
                default: tcState_q <= ELT_TC_IDLE;
            endcase
        end
    end

    // a 1 s preset turns on after one second of input and then stays on while the input stays on
    always_comb begin
        if (!presetOn) begin
            tcOut = 1'b0; // RULE26
        end else if (tcCfg_q.actionModeSelect) begin
            tcOut = tcState_q == ELT_TC_PULSE; // RULE20
        end else begin
            tcOut = tcIn && tcCount_q >= tcCfg_q.preset; // RULE17 RULE19
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    logic [2:0] eventRelay_q;
    logic [4:0] digitalOutput_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            eventRelay_q <= 3'h0;
            digitalOutput_q <= 5'h00;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (combCfg_q.target == 3'(i + 1)) begin
                    eventRelay_q[i] <= combOut; // RULE9
                end else begin
                    eventRelay_q[i] <= (i == 0) ? alarmOut : 1'b0;
                end
                digitalOutput_q[i] <= combCfg_q.target == 3'(i + 4) && combOut; // RULE9
            end
            digitalOutput_q[3] <= tcCfg_q.target == 2'h1 && tcOut; // RULE15
            digitalOutput_q[4] <= tcCfg_q.target == 2'h2 && tcOut; // RULE15
        end
    end

    assign status = {10'h0, tcState_q == ELT_TC_PULSE, inhibitArmed_q, gated, eventRelay_q, digitalOutput_q, level_q};
    assign wbAck = ack_q;
    assign wbDatOut = datOut_q;
    assign eventRelay = eventRelay_q;
    assign digitalOutput = digitalOutput_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_inhibit_holds_off: assert property (inhibitUsed && inhibitArmed_q && processInZone && !scaleOver
        && combCfg_q.target != 3'h1 |=> !eventRelay_q[0]) else $error("alarm on while inhibited"); // RULE1
    a_sv_change_arms: assert property (eventCfg_q.inhibitSelect == ELT_IH_TWO && setValueChanged
        |=> inhibitArmed_q) else $error("set value change did not arm"); // RULE3
    a_scale_force_on: assert property (inhibitUsed && scaleOver && !standbyState && combCfg_q.target != 3'h1
        |=> eventRelay_q[0]) else $error("scale-over did not force alarm on"); // RULE5
    a_scale_force_off: assert property (eventCfg_q.inhibitSelect == ELT_IH_THREE && scaleOver
        && combCfg_q.target != 3'h1 |=> !eventRelay_q[0]) else $error("scale-over did not force off"); // RULE6
    a_standby_disables: assert property (standbyState && !eventCfg_q.standbyEventEnable
        && combCfg_q.target != 3'h1 |=> !eventRelay_q[0]) else $error("alarm on in standby"); // RULE7
    a_none_reads_zero: assert property (combCfg_q.firstLogicSource == 4'h0 |-> !gated[0])
        else $error("unassigned source not zero"); // RULE11
    a_and_to_output: assert property (combCfg_q.target == 3'h4 && combCfg_q.logicFunctionSelect == ELT_FN_AND
        |=> digitalOutput_q[0] == $past(gated[0] && gated[1])) else $error("and result wrong"); // RULE8
    a_toggle_flips: assert property (riseIn[0] |=> toggle_q[0] != $past(toggle_q[0]))
        else $error("toggle did not flip"); // RULE13
    a_preset_off_quiet: assert property (!presetOn ##1 !presetOn |-> !digitalOutput_q[3] && !digitalOutput_q[4])
        else $error("timer output with preset off"); // RULE26
    a_ack_single: assert property (ack_q |=> !ack_q) else $error("ack held two cycles");

    c_counter_pulse: cover property (tcState_q == ELT_TC_IDLE ##1 tcState_q == ELT_TC_PULSE);
    c_inhibit_release: cover property (inhibitArmed_q && !processInZone ##1 processInZone && !inhibitArmed_q);
    c_xor_output: cover property (combCfg_q.logicFunctionSelect == ELT_FN_XOR && combOut);
endmodule : elt_top
`default_nettype wire

// [verif/elt_contacts.sv]
// contact model for the digital input pins of the event logic block
// assumes the bench asks for contact levels; the model keeps each state long enough to count
`timescale 1ns/1ps
`default_nettype none
module elt_contacts #(
    parameter int HOLD = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // requested contact levels
    input wire logic [9:0] request,
    // contact pins
    output logic [9:0] contact
);
    int heldQ;
    // a real contact cannot chatter faster than this, so a request waits out the hold
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            contact <= '0;
            heldQ <= 0;
        end else if (request != contact && heldQ >= HOLD) begin
            contact <= request;
            heldQ <= 0;
        end else begin
            heldQ <= heldQ + 1;
        end
    end
endmodule : elt_contacts
`default_nettype wire

// [verif/elt_top_bench.sv]
// testbench of the event logic block: scenario tasks over Wishbone and the contact model
// assumes shortened counts: debounce 4 cycles, one second 10 cycles
`timescale 1ns/1ps
`default_nettype none
module elt_top_bench;
    import elt_pkg::*;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic wbCyc = 1'h0;
    logic wbStb = 1'h0;
    logic wbWe = 1'h0;
    logic [3:0] wbAdr = 4'h0;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0;
    logic [31:0] wbDatOut;
    logic wbAck;
    logic processInZone = 1'h0;
    logic scaleOver = 1'h0;
    logic standbyState = 1'h0;
    logic setValueChanged = 1'h0;
    logic [9:0] diReq = 10'h0;
    logic [9:0] digitalInput;
    logic [2:0] eventRelay;
    logic [4:0] digitalOutput;
    logic [7:0] outs;
    logic [31:0] rd;
    int n_errors = 0;
    int checks_done = 0;
    assign outs = {digitalOutput, eventRelay};
    always #12.5 clock = ~clock;
    elt_top #(.DEBOUNCE_CYCLES(22'h4), .SECOND_CYCLES(26'hA)) i_elt_top (.clock(clock), .reset(reset),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
        .wbDatOut(wbDatOut), .wbAck(wbAck), .processInZone(processInZone), .scaleOver(scaleOver),
        .standbyState(standbyState), .setValueChanged(setValueChanged), .digitalInput(digitalInput),
        .eventRelay(eventRelay), .digitalOutput(digitalOutput));
    elt_contacts #(.HOLD(8)) i_elt_contacts (.clock(clock), .reset(reset), .request(diReq), .contact(digitalInput));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] wdat);
        @(posedge clock);
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hF;
        wbDatIn <= wdat;
        do @(posedge clock); while (wbAck !== 1'h1);
        rd = wbDatOut;
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
        wbWe <= 1'h0;
    endtask : wbXfer
    // settle covers contact hold plus debounce; the bounded wait absorbs the rest
    task waitOut(input int idx, input logic exp, input int settle);
        int n;
        repeat (settle) @(posedge clock);
        n = 0;
        while (outs[idx] !== exp && n < 60) begin
            @(posedge clock);
            n++;
        end
        chk($sformatf("out%0d", idx), {31'h0, exp}, {31'h0, outs[idx]});
    endtask : waitOut
    task setDi(input int idx, input logic v);
        @(posedge clock);
        diReq[idx] <= v;
    endtask : setDi
    function automatic logic [31:0] comb(elt_func_t f, logic [3:0] s1, elt_gate_t g1, logic [3:0] s2, elt_gate_t g2);
        elt_comb_cfg_t c;
        c = '0;
        c.logicFunctionSelect = f;
        c.target = 3'h4;
        c.firstLogicSource = s1;
        c.firstInputGating = g1;
        c.secondLogicSource = s2;
        c.secondInputGating = g2;
        return c;
    endfunction : comb
    function automatic logic [31:0] tc(logic [1:0] tgt, logic md, logic [3:0] src, logic [12:0] pre);
        elt_tc_cfg_t c;
        c = '0;
        c.target = tgt;
        c.actionModeSelect = md;
        c.timerSource = src;
        c.preset = pre;
        return c;
    endfunction : tc
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_regs;
        wbXfer(1'h0, 4'h0, 32'h0);
        chk("event", 32'h0, rd);
        wbXfer(1'h0, 4'h4, 32'h0);
        chk("combiner", 32'h0, rd);
        wbXfer(1'h0, 4'h8, 32'h0);
        chk("timer", 32'h0, rd);
        wbXfer(1'h1, 4'h4, 32'hFFFF_FFFF);
        wbXfer(1'h0, 4'h4, 32'h0);
        chk("combiner rw", 32'h003F_3F73, rd);
        wbXfer(1'h1, 4'h8, 32'hFFFF_FFFF);
        wbXfer(1'h0, 4'h8, 32'h0);
        chk("timer rw", 32'h1FFF_00FB, rd);
        wbXfer(1'h1, 4'h2, 32'hFFFF_FFFF);
        wbXfer(1'h0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask : t_regs
    task t_combiner;
        logic e;
        for (int f = 0; f < 3; f++) begin
            wbXfer(1'h1, 4'h4, comb(elt_func_t'(2'(f)), 4'h1, ELT_GATE_BUF, 4'h2, ELT_GATE_BUF));
            for (int v = 0; v < 4; v++) begin
                e = (f == 0) ? (v == 3) : (f == 1) ? (v != 0) : (v == 1 || v == 2);
                @(posedge clock);
                diReq[1:0] <= 2'(v);
                waitOut(3, e, 12);
            end
        end
        wbXfer(1'h1, 4'h4, comb(ELT_FN_AND, 4'h1, ELT_GATE_INV, 4'h2, ELT_GATE_BUF));
        setDi(0, 1'h0);
        waitOut(3, 1'h1, 12);
        wbXfer(1'h1, 4'h4, comb(ELT_FN_OR, 4'h0, ELT_GATE_INV, 4'h0, ELT_GATE_INV));
        waitOut(3, 1'h0, 12);
        setDi(1, 1'h0);
        wbXfer(1'h1, 4'h4, comb(ELT_FN_OR, 4'h3, ELT_GATE_TOGGLE, 4'h0, ELT_GATE_BUF));
        for (int k = 0; k < 2; k++) begin
            setDi(2, 1'h1);
            waitOut(3, k == 0, 12);
            setDi(2, 1'h0);
            waitOut(3, k == 0, 20);
        end
    endtask : t_combiner
    task t_timer;
        wbXfer(1'h1, 4'h8, tc(2'h1, 1'h0, 4'h5, 13'h0));
        setDi(4, 1'h1);
        waitOut(6, 1'h0, 40);
        wbXfer(1'h1, 4'h8, tc(2'h1, 1'h0, 4'h5, 13'h2));
        waitOut(6, 1'h0, 8);
        waitOut(6, 1'h1, 4);
        setDi(4, 1'h0);
        waitOut(6, 1'h0, 12);
        wbXfer(1'h1, 4'h8, tc(2'h2, 1'h1, 4'h6, 13'h2));
        setDi(5, 1'h1);
        setDi(5, 1'h0);
        waitOut(7, 1'h0, 20);
        setDi(5, 1'h1);
        waitOut(7, 1'h1, 0);
        waitOut(7, 1'h0, 0);
        setDi(5, 1'h0);
    endtask : t_timer
    task t_inhibit;
        wbXfer(1'h1, 4'h0, 32'h1);
        @(posedge clock);
        processInZone <= 1'h1;
        standbyState <= 1'h1;
        @(posedge clock);
        standbyState <= 1'h0;
        waitOut(0, 1'h0, 6);
        processInZone <= 1'h0;
        waitOut(0, 1'h0, 3);
        processInZone <= 1'h1;
        waitOut(0, 1'h1, 0);
        wbXfer(1'h1, 4'h0, 32'h2);
        setValueChanged <= 1'h1;
        @(posedge clock);
        setValueChanged <= 1'h0;
        waitOut(0, 1'h0, 4);
        scaleOver <= 1'h1;
        waitOut(0, 1'h1, 0);
        wbXfer(1'h1, 4'h0, 32'h3);
        waitOut(0, 1'h0, 0);
        scaleOver <= 1'h0;
        waitOut(0, 1'h1, 0);
        standbyState <= 1'h1;
        waitOut(0, 1'h0, 0);
        wbXfer(1'h1, 4'h0, 32'h7);
        waitOut(0, 1'h1, 0);
        standbyState <= 1'h0;
    endtask : t_inhibit
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'h0;
        t_regs();
        t_combiner();
        t_timer();
        t_inhibit();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end
endmodule : elt_top_bench
`default_nettype wire
